// *** sdwl_defines.svh ***
`ifndef SDWL_DEFINES_SVH
`define SDWL_DEFINES_SVH

// widths
`define SDWL_ADDR_W 4
`define SDWL_DATA_W 16
`define SDWL_DQ_W 8
`define SDWL_CNT_W 10

// register indices on the plain register port
`define SDWL_ADDR_MR1 4'h0
`define SDWL_ADDR_CTRL 4'h1
`define SDWL_ADDR_STAT 4'h2

// mode register one field positions and masks
`define SDWL_MR1_LEVEL 7
`define SDWL_MR1_QOFF 12
`define SDWL_MR1_LEVEL_MASK 16'h0080
`define SDWL_MR1_QOFF_MASK 16'h1000
`define SDWL_MR1_EXIT_MASK 16'h1A66
`define SDWL_MR1_NOM_MASK 16'h0244
`define SDWL_MR1_RST 16'h0000

// control register fields
`define SDWL_CTRL_SREF 0
`define SDWL_CTRL_DLLRST 1
`define SDWL_CTRL_PRIME 2
`define SDWL_CTRL_MASK 16'h0005
`define SDWL_CTRL_RST 16'h0000

// status register fields
`define SDWL_STAT_LEVEL 0
`define SDWL_STAT_FBVAL 1
`define SDWL_STAT_FB 2
`define SDWL_STAT_TRDY 3
`define SDWL_STAT_CKIGN 4
`define SDWL_STAT_LOCK 5
`define SDWL_STAT_VIOL 6

// timing, times in ns, lock time in clock cycles
`define SDWL_CLK_NS 10
`define SDWL_MOD_NS 15
`define SDWL_DQSEN_NS 25
`define SDWL_WLO_NS 9
`define SDWL_CKSRE_NS 10
`define SDWL_DLLK_NCK 512

// least times round up, the longest time rounds down to at least one
`define SDWL_MOD_CYC 10'((`SDWL_MOD_NS + `SDWL_CLK_NS - 1) / `SDWL_CLK_NS)
`define SDWL_DQSEN_CYC 10'((`SDWL_DQSEN_NS + `SDWL_CLK_NS - 1) / `SDWL_CLK_NS)
`define SDWL_WLO_CYC 10'(((`SDWL_WLO_NS / `SDWL_CLK_NS) < 1) ? 1 : \
  (`SDWL_WLO_NS / `SDWL_CLK_NS))
`define SDWL_CKSRE_CYC 10'((`SDWL_CKSRE_NS + `SDWL_CLK_NS - 1) / `SDWL_CLK_NS)
`define SDWL_DLLK_CYC 10'(`SDWL_DLLK_NCK)

`endif

// *** sdwl_pkg.sv ***
`default_nettype none
package sdwl_pkg;

  // pin levels that cross into the clk domain together
  typedef struct packed {
    logic ck;
    logic strobe;
    logic term;
    logic cke;
  } sdwl_pins_s;

  // leveling progress
  typedef enum logic [1:0] {
    LV_IDLE = 2'b00,
    LV_SETUP = 2'b01,
    LV_ARMED = 2'b10,
    LV_FEED = 2'b11
  } sdwl_lv_e;

endpackage : sdwl_pkg
`default_nettype wire

// *** sdwl_sync.sv ***
`timescale 1ns/100ps
`default_nettype none
module sdwl_sync #(
  parameter int WIDTH = 1
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_ff;
  logic [WIDTH-1:0] sync_ff;

  // two stages; only the second one is read outside
  always_ff @(posedge clk) begin
    if (!resetn) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= async_in;
      sync_ff <= meta_ff;
    end
  end

  assign sync_out = sync_ff;

endmodule : sdwl_sync
`default_nettype wire

// *** sdwl_top.sv ***
// Function
// [R1] controller keeps clock period fixed otherwise
// [R2] frequency changes only in self refresh/power-down
// [R3] self refresh: clock ignored after hold interval
// [R4] new frequency within speed grade range
// [R5] power-down: termination pin low if enabled
// [R6] controller waits hold, keeps pins low
// [R7] stable clocks before exit, then loop reset
// [R8] further mode-sets update latencies, enable high
// [R9] relock: termination low, enable high, then ready
// [R10] level bit set enters, cleared leaves leveling
// [R11] output-disable bit one disables data outputs
// [R12] leveling: pin switches strobe termination only
// [R13] outputs enabled: only three termination settings
// [R14] leveling: only idle and two mode-sets allowed
// [R15] exit write may update listed other bits
// [R16] other ranks get outputs disabled
// [R17] termination accepted only after mode-set delay
// [R18] strobe terminated after strobe-enable delay
// [R19] controller sends single edge after delays
// [R20] strobe rise samples clock, feedback after delay
// [R21] prime bit mode: other data bits low
// [R22] data undriven until first feedback
// [R23] controller tunes delay until zero-to-one seen
//
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/100ps
`default_nettype none
`include "sdwl_defines.svh"
module sdwl_top (
  input wire logic clk,
  input wire logic resetn,
  input wire logic [`SDWL_ADDR_W-1:0] bus_addr,
  input wire logic [`SDWL_DATA_W-1:0] bus_wdata,
  input wire logic bus_wr,
  input wire logic bus_rd,
  output logic [`SDWL_DATA_W-1:0] bus_rdata,
  input wire logic mem_ck,
  input wire logic strobe_in,
  input wire logic termination_control_pin,
  input wire logic cke_pin,
  output logic [`SDWL_DQ_W-1:0] data_out,
  output logic data_oe_n,
  output logic strobe_term_en,
  output logic data_term_en
);

  sdwl_pkg::sdwl_pins_s pin_raw;
  sdwl_pkg::sdwl_pins_s pin_s;
  sdwl_pkg::sdwl_lv_e lv_state_ff;
  logic [`SDWL_DATA_W-1:0] mode_register_one_ff;
  logic [`SDWL_DATA_W-1:0] ctrl_ff;
  logic [`SDWL_DATA_W-1:0] rdata_ff;
  logic [`SDWL_DATA_W-1:0] status_word;
  logic [`SDWL_DATA_W-1:0] mr1_fixed;
  logic [`SDWL_CNT_W-1:0] mod_cnt_ff;
  logic [`SDWL_CNT_W-1:0] dqsen_cnt_ff;
  logic [`SDWL_CNT_W-1:0] wlo_cnt_ff;
  logic [`SDWL_CNT_W-1:0] sr_cnt_ff;
  logic [`SDWL_CNT_W-1:0] dll_cnt_ff;
  logic [`SDWL_DQ_W-1:0] data_out_ff;
  logic data_oe_n_ff;
  logic strobe_term_ff;
  logic data_term_ff;
  logic strobe_d_ff;
  logic term_ready_ff;
  logic smp_ff;
  logic fb_ff;
  logic fb_valid_ff;
  logic clk_ignore_ff;
  logic dll_locked_ff;
  logic viol_ff;
  logic wr_mr1;
  logic wr_ctrl;
  logic wr_stat;
  logic lv_active;
  logic lv_accept;
  logic term_on;
  logic strobe_rise;
  logic sample_go;
  logic fb_fire;
  logic nom_en;
  logic dll_start;
  logic dll_busy;

  // every pin level is resynchronised before any logic looks at it
  assign pin_raw = '{ck: mem_ck, strobe: strobe_in,
                     term: termination_control_pin, cke: cke_pin};

  sdwl_sync #(
    .WIDTH($bits(sdwl_pkg::sdwl_pins_s))
  ) u_pin_sync (
    .clk(clk),
    .resetn(resetn),
    .async_in(pin_raw),
    .sync_out(pin_s)
  );

  // register port decode
  assign wr_mr1 = bus_wr && (bus_addr == `SDWL_ADDR_MR1);
  assign wr_ctrl = bus_wr && (bus_addr == `SDWL_ADDR_CTRL);
  assign wr_stat = bus_wr && (bus_addr == `SDWL_ADDR_STAT);
  assign dll_start = wr_ctrl && bus_wdata[`SDWL_CTRL_DLLRST];
  assign lv_active = (lv_state_ff != sdwl_pkg::LV_IDLE);
  assign lv_accept = (lv_state_ff == sdwl_pkg::LV_ARMED) ||
                     (lv_state_ff == sdwl_pkg::LV_FEED);
  assign nom_en = |(mode_register_one_ff & `SDWL_MR1_NOM_MASK);
  assign term_on = lv_accept && pin_s.term;
  assign strobe_rise = pin_s.strobe && !strobe_d_ff;
  assign sample_go = strobe_rise && lv_accept && !clk_ignore_ff; // R20 R3
  assign fb_fire = (wlo_cnt_ff == `SDWL_CNT_W'(1));
  assign dll_busy = (dll_cnt_ff != '0);
  assign mr1_fixed = mode_register_one_ff &
                     ~(`SDWL_MR1_EXIT_MASK | `SDWL_MR1_LEVEL_MASK);

  // mode register one; while leveling only a subset of bits may move
  always_ff @(posedge clk) begin
    if (!resetn) begin
      mode_register_one_ff <= `SDWL_MR1_RST;
    end else if (wr_mr1) begin
      if (!lv_active) begin
        mode_register_one_ff <= bus_wdata; // R10 R11
      end else if (bus_wdata[`SDWL_MR1_LEVEL]) begin
        // only the output-disable bit follows the write
        mode_register_one_ff <= (mode_register_one_ff &
          ~`SDWL_MR1_QOFF_MASK) | (bus_wdata & `SDWL_MR1_QOFF_MASK); // R11
      end else begin
        mode_register_one_ff <= (mode_register_one_ff &
          ~(`SDWL_MR1_EXIT_MASK | `SDWL_MR1_LEVEL_MASK)) |
          (bus_wdata & `SDWL_MR1_EXIT_MASK); // R15 R10
      end
    end
  end

  // control register; the loop-reset bit is a pulse and reads zero
  always_ff @(posedge clk) begin
    if (!resetn) begin
      ctrl_ff <= `SDWL_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_ff <= bus_wdata & `SDWL_CTRL_MASK;
    end
  end

  // leveling progress, driven by the level bit of mode register one
  always_ff @(posedge clk) begin
    if (!resetn) begin
      lv_state_ff <= sdwl_pkg::LV_IDLE;
      mod_cnt_ff <= '0;
    end else begin
      case (lv_state_ff)
        sdwl_pkg::LV_IDLE: begin
          if (mode_register_one_ff[`SDWL_MR1_LEVEL]) begin
            lv_state_ff <= sdwl_pkg::LV_SETUP; // R10
            mod_cnt_ff <= `SDWL_MOD_CYC;
          end
        end
        sdwl_pkg::LV_SETUP: begin
          if (!mode_register_one_ff[`SDWL_MR1_LEVEL]) begin
            lv_state_ff <= sdwl_pkg::LV_IDLE;
          end else if (mod_cnt_ff <= `SDWL_CNT_W'(1)) begin
            lv_state_ff <= sdwl_pkg::LV_ARMED; // R17
          end else begin
            mod_cnt_ff <= mod_cnt_ff - `SDWL_CNT_W'(1);
          end
        end
        sdwl_pkg::LV_ARMED: begin
          if (!mode_register_one_ff[`SDWL_MR1_LEVEL]) begin
            lv_state_ff <= sdwl_pkg::LV_IDLE;
          end else if (fb_fire) begin
            lv_state_ff <= sdwl_pkg::LV_FEED; // R22
          end
        end
        sdwl_pkg::LV_FEED: begin
          if (!mode_register_one_ff[`SDWL_MR1_LEVEL]) begin
            lv_state_ff <= sdwl_pkg::LV_IDLE; // R10
          end
        end
        default: begin
          lv_state_ff <= sdwl_pkg::LV_IDLE;
        end
      endcase
    end
  end

  // termination: in leveling the pin drives strobe termination only
  always_ff @(posedge clk) begin
    if (!resetn) begin
      strobe_term_ff <= 1'b0;
      data_term_ff <= 1'b0;
    end else if (lv_active) begin
      strobe_term_ff <= term_on; // R12 R17
      data_term_ff <= 1'b0; // R12
    end else begin
      strobe_term_ff <= pin_s.term && nom_en;
      data_term_ff <= pin_s.term && nom_en;
    end
  end

  // strobe termination is settled once held for the enable delay
  always_ff @(posedge clk) begin
    if (!resetn) begin
      dqsen_cnt_ff <= '0;
      term_ready_ff <= 1'b0;
    end else if (!term_on) begin
      dqsen_cnt_ff <= '0;
      term_ready_ff <= 1'b0;
    end else if (dqsen_cnt_ff >= `SDWL_DQSEN_CYC) begin
      term_ready_ff <= 1'b1; // R18
    end else begin
      dqsen_cnt_ff <= dqsen_cnt_ff + `SDWL_CNT_W'(1);
    end
  end

  // strobe edge detect on the synchronised level
  always_ff @(posedge clk) begin
    if (!resetn) begin
      strobe_d_ff <= 1'b0;
    end else begin
      strobe_d_ff <= pin_s.strobe;
    end
  end

  // sample clock on strobe rise, release after the output delay
  always_ff @(posedge clk) begin
    if (!resetn) begin
      smp_ff <= 1'b0;
      wlo_cnt_ff <= '0;
    end else if (sample_go) begin
      smp_ff <= pin_s.ck; // R20
      wlo_cnt_ff <= `SDWL_WLO_CYC;
    end else if (wlo_cnt_ff != '0) begin
      wlo_cnt_ff <= wlo_cnt_ff - `SDWL_CNT_W'(1);
    end
  end

  // feedback value; forgotten when leveling ends
  always_ff @(posedge clk) begin
    if (!resetn) begin
      fb_ff <= 1'b0;
      fb_valid_ff <= 1'b0;
    end else if (!lv_active) begin
      fb_ff <= 1'b0;
      fb_valid_ff <= 1'b0;
    end else if (fb_fire) begin
      fb_ff <= smp_ff; // R20
      fb_valid_ff <= 1'b1;
    end
  end

  // data pins: undriven before first feedback or with outputs disabled
  always_ff @(posedge clk) begin
    if (!resetn) begin
      data_out_ff <= '0;
      data_oe_n_ff <= 1'b1;
    end else if (lv_active && fb_valid_ff &&
                 !mode_register_one_ff[`SDWL_MR1_QOFF]) begin
      data_oe_n_ff <= 1'b0; // R11 R22
      if (ctrl_ff[`SDWL_CTRL_PRIME]) begin
        data_out_ff <= {{(`SDWL_DQ_W-1){1'b0}}, fb_ff}; // R21
      end else begin
        data_out_ff <= {`SDWL_DQ_W{fb_ff}}; // R21
      end
    end else begin
      data_out_ff <= '0;
      data_oe_n_ff <= 1'b1;
    end
  end

  // self refresh with clock enable low: clock ignored after hold time
  always_ff @(posedge clk) begin
    if (!resetn) begin
      sr_cnt_ff <= '0;
      clk_ignore_ff <= 1'b0;
    end else if (!ctrl_ff[`SDWL_CTRL_SREF] || pin_s.cke) begin
      sr_cnt_ff <= '0;
      clk_ignore_ff <= 1'b0;
    end else if (sr_cnt_ff >= `SDWL_CKSRE_CYC) begin
      clk_ignore_ff <= 1'b1; // R3
    end else begin
      sr_cnt_ff <= sr_cnt_ff + `SDWL_CNT_W'(1);
    end
  end

  // delay-locked loop relock timer; new frequency valid once it ends
  always_ff @(posedge clk) begin
    if (!resetn) begin
      dll_cnt_ff <= '0;
      dll_locked_ff <= 1'b1;
    end else if (dll_start) begin
      dll_cnt_ff <= `SDWL_DLLK_CYC;
      dll_locked_ff <= 1'b0; // R9
    end else if (dll_busy) begin
      dll_cnt_ff <= dll_cnt_ff - `SDWL_CNT_W'(1);
      dll_locked_ff <= (dll_cnt_ff == `SDWL_CNT_W'(1)); // R9
    end
  end

  // sticky flag for pin misuse during relock; a new event beats clear
  always_ff @(posedge clk) begin
    if (!resetn) begin
      viol_ff <= 1'b0;
    end else if (dll_busy && (pin_s.term || !pin_s.cke)) begin
      viol_ff <= 1'b1; // R9
    end else if (wr_stat && bus_wdata[`SDWL_STAT_VIOL]) begin
      viol_ff <= 1'b0;
    end
  end

  // status word assembly
  always_comb begin
    status_word = '0;
    status_word[`SDWL_STAT_LEVEL] = lv_active;
    status_word[`SDWL_STAT_FBVAL] = fb_valid_ff;
    status_word[`SDWL_STAT_FB] = fb_ff;
    status_word[`SDWL_STAT_TRDY] = term_ready_ff;
    status_word[`SDWL_STAT_CKIGN] = clk_ignore_ff;
    status_word[`SDWL_STAT_LOCK] = dll_locked_ff;
    status_word[`SDWL_STAT_VIOL] = viol_ff;
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (!resetn) begin
      rdata_ff <= '0;
    end else if (bus_rd) begin
      case (bus_addr)
        `SDWL_ADDR_MR1: rdata_ff <= mode_register_one_ff;
        `SDWL_ADDR_CTRL: rdata_ff <= ctrl_ff;
        `SDWL_ADDR_STAT: rdata_ff <= status_word;
        default: rdata_ff <= '0;
      endcase
    end else begin
      rdata_ff <= '0;
    end
  end

  assign bus_rdata = rdata_ff;
  assign data_out = data_out_ff;
  assign data_oe_n = data_oe_n_ff;
  assign strobe_term_en = strobe_term_ff;
  assign data_term_en = data_term_ff;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!resetn);

  sequence seq_entry;
    (lv_state_ff == sdwl_pkg::LV_IDLE) &&
      mode_register_one_ff[`SDWL_MR1_LEVEL];
  endsequence

  sequence seq_sample;
    sample_go;
  endsequence

  chk_level_entry: assert property (seq_entry |=> // R10
    lv_state_ff == sdwl_pkg::LV_SETUP)
    else $error("leveling not entered");
  chk_level_exit: assert property (lv_active && // R10
    !mode_register_one_ff[`SDWL_MR1_LEVEL] |=> !lv_active)
    else $error("leveling not left");
  chk_qoff_hiz: assert property ( // R11
    $past(mode_register_one_ff[`SDWL_MR1_QOFF]) |-> data_oe_n_ff)
    else $error("data driven with outputs disabled");
  chk_data_term_off: assert property (lv_active |=> !data_term_ff) // R12
    else $error("data termination on in leveling");
  chk_setup_no_term: assert property (seq_entry |=> // R17
    !strobe_term_ff [*2])
    else $error("termination taken before mode-set delay");
  // ready may only rise after the pin was accepted for the whole delay
  chk_term_ready: assert property ($rose(term_ready_ff) |-> // R18
    $past(term_on) && $past(term_on, 2) && $past(term_on, 3) &&
    $past(term_on, 4))
    else $error("strobe ready before enable delay");
  // feedback must carry the clock level seen at the strobe rise
  chk_fb_delay: assert property (seq_sample |-> // R20
    ##2 (fb_valid_ff && fb_ff == $past(pin_s.ck, 2)))
    else $error("feedback not presented");
  chk_prime_low: assert property (!data_oe_n_ff && // R21
    $past(ctrl_ff[`SDWL_CTRL_PRIME]) |-> data_out_ff[`SDWL_DQ_W-1:1] == '0)
    else $error("non-prime bits not low");
  chk_undef_hiz: assert property ( // R22
    lv_state_ff == sdwl_pkg::LV_ARMED |=> data_oe_n_ff)
    else $error("data driven before first feedback");
  chk_clk_ignore: assert property ( // R3
    (ctrl_ff[`SDWL_CTRL_SREF] && !pin_s.cke) [*2] |=>
    clk_ignore_ff && !sample_go)
    else $error("clock not ignored after hold time");
  chk_relock_hold: assert property (dll_start |=> // R9
    !dll_locked_ff [*8])
    else $error("lock reported too early");
  chk_exit_mask: assert property (wr_mr1 && lv_active && // R15
    !bus_wdata[`SDWL_MR1_LEVEL] |=> mr1_fixed == $past(mr1_fixed))
    else $error("exit write changed a protected bit");

endmodule : sdwl_top
`default_nettype wire

// *** sdwl_ctrl_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module sdwl_ctrl_model #(
  parameter int CK_HALF_NS = 40
) (
  input wire logic term_req,
  input wire logic cke_req,
  output logic mem_ck,
  output logic strobe,
  output logic term,
  output logic cke
);
  // free-running memory clock; the period never moves, so no change of
  // rate ever happens outside the two permitted power states
  initial mem_ck = 1'b0;
  always #(CK_HALF_NS) mem_ck = ~mem_ck;

  // strobe parked low; termination and clock enable follow the bench,
  // which keeps termination low and enable high unless a test says so
  initial strobe = 1'b0;
  assign term = term_req;
  assign cke = cke_req;

  // one rising strobe edge, launched a set delay after a clock rise;
  // held high half a clock so the synchroniser cannot miss it
  task automatic pulse(input int dly_ns);
    @(posedge mem_ck);
    #(dly_ns);
    strobe = 1'b1;
    #(CK_HALF_NS);
    strobe = 1'b0;
  endtask : pulse
endmodule : sdwl_ctrl_model
`default_nettype wire

// *** testbench.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "sdwl_defines.svh"
module testbench;
  logic clk;
  logic resetn;
  logic [`SDWL_ADDR_W-1:0] bus_addr;
  logic [`SDWL_DATA_W-1:0] bus_wdata;
  logic bus_wr, bus_rd;
  logic [`SDWL_DATA_W-1:0] bus_rdata;
  logic [`SDWL_DATA_W-1:0] rd_val;
  logic mem_ck, strobe_in, termination_control_pin, cke_pin;
  logic term_req, cke_req;
  logic [`SDWL_DQ_W-1:0] data_out;
  logic data_oe_n, strobe_term_en, data_term_en;
  int fail_count, cmp_count;

  sdwl_ctrl_model i_sdwl_ctrl_model (
    .term_req(term_req), .cke_req(cke_req),
    .mem_ck(mem_ck), .strobe(strobe_in),
    .term(termination_control_pin), .cke(cke_pin)
  );

  sdwl_top i_sdwl_top (
    .clk(clk), .resetn(resetn), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata(bus_rdata), .mem_ck(mem_ck), .strobe_in(strobe_in),
    .termination_control_pin(termination_control_pin),
    .cke_pin(cke_pin), .data_out(data_out), .data_oe_n(data_oe_n),
    .strobe_term_en(strobe_term_en), .data_term_en(data_term_en)
  );

  // 100 MHz system clock
  initial clk = 1'b0;
  always #5 clk = ~clk;

  // one-cycle write strobe
  task automatic bus_write(input logic [`SDWL_ADDR_W-1:0] a,
                           input logic [`SDWL_DATA_W-1:0] d);
    @(posedge clk);
    bus_wr <= 1'b1;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge clk);
    bus_wr <= 1'b0;
  endtask : bus_write

  // read data stands only in the cycle after the strobe
  task automatic bus_read(input logic [`SDWL_ADDR_W-1:0] a);
    @(posedge clk);
    bus_rd <= 1'b1;
    bus_addr <= a;
    @(posedge clk);
    bus_rd <= 1'b0;
    #1;
    rd_val = bus_rdata;
  endtask : bus_read

  // register result, masked so unrelated status bits stay out
  task automatic check_reg(input string nm,
                           input logic [`SDWL_ADDR_W-1:0] a,
                           input logic [`SDWL_DATA_W-1:0] exp,
                           input logic [`SDWL_DATA_W-1:0] msk);
    bus_read(a);
    cmp_count++;
    if ((rd_val & msk) !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, rd_val & msk);
    end
  endtask : check_reg

  // single pin result
  task automatic check_pin(input string nm, input logic exp,
                           input logic got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %b seen %b", nm, exp, got);
    end
  endtask : check_pin

  // data pin byte result
  task automatic check_byte(input string nm,
                            input logic [`SDWL_DQ_W-1:0] exp,
                            input logic [`SDWL_DQ_W-1:0] got);
    cmp_count++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask : check_byte

  // one strobe edge, then the fixed feedback latency plus margin
  task automatic level_pulse(input int dly, input logic [7:0] exp,
                             input logic exp_oe_n);
    i_sdwl_ctrl_model.pulse(dly);
    repeat (12) @(posedge clk);
    #1;
    check_pin("data_oe_n", exp_oe_n, data_oe_n);
    if (exp_oe_n == 1'b0) begin
      check_byte("data_out", exp, data_out);
    end
  endtask : level_pulse

  task automatic give_verdict();
    if (fail_count == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : give_verdict

  // hang guard: a run that never ends counts as a mismatch
  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    give_verdict();
  end

  // main sequence; two reset edges clear the syncs as well
  initial begin
    fail_count = 0;
    cmp_count = 0;
    term_req = 1'b0;
    cke_req = 1'b1;
    resetn = 1'b0;
    bus_addr = '0;
    bus_wdata = '0;
    bus_wr = 1'b0;
    bus_rd = 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    #1;
    check_pin("data_oe_n", 1'b1, data_oe_n);
    check_pin("strobe_term_en", 1'b0, strobe_term_en);
    check_reg("mr1", `SDWL_ADDR_MR1, 16'h0000, 16'hFFFF);
    check_reg("stat", `SDWL_ADDR_STAT, 16'h0020, 16'hFFFF);
    bus_write(4'hF, 16'hFFFF);
    check_reg("unmapped", 4'hF, 16'h0000, 16'hFFFF);
    // enter leveling; outputs stay off until the first sample
    bus_write(`SDWL_ADDR_MR1, 16'h0080);
    check_reg("stat_level", `SDWL_ADDR_STAT, 16'h0001, 16'h0001);
    check_pin("data_oe_n", 1'b1, data_oe_n);
    repeat (4) @(posedge clk);
    term_req <= 1'b1;
    repeat (8) @(posedge clk);
    #1;
    check_pin("strobe_term_en", 1'b1, strobe_term_en);
    check_pin("data_term_en", 1'b0, data_term_en);
    check_reg("stat_trdy", `SDWL_ADDR_STAT, 16'h0008, 16'h0008);
    // sweep the strobe from the low phase to the high phase
    level_pulse(60, 8'h00, 1'b0);
    check_reg("stat_fb0", `SDWL_ADDR_STAT, 16'h0003, 16'h0007);
    level_pulse(20, 8'hFF, 1'b0);
    check_reg("stat_fb1", `SDWL_ADDR_STAT, 16'h0007, 16'h0007);
    // prime-bit mode: other bits held low
    bus_write(`SDWL_ADDR_CTRL, 16'h0004);
    check_reg("ctrl", `SDWL_ADDR_CTRL, 16'h0004, 16'hFFFF);
    level_pulse(20, 8'h01, 1'b0);
    level_pulse(60, 8'h00, 1'b0);
    // during leveling only the output-disable bit moves
    bus_write(`SDWL_ADDR_MR1, 16'h1FFF);
    check_reg("mr1_qoff", `SDWL_ADDR_MR1, 16'h1080, 16'hFFFF);
    level_pulse(20, 8'h00, 1'b1);
    term_req <= 1'b0;
    // exit write updates only the listed bits
    bus_write(`SDWL_ADDR_MR1, 16'hFF7F);
    check_reg("mr1_exit", `SDWL_ADDR_MR1, 16'h1A66, 16'hFFFF);
    check_reg("stat_exit", `SDWL_ADDR_STAT, 16'h0000, 16'h0001);
    // outside leveling the pin switches data termination as well
    term_req <= 1'b1;
    repeat (4) @(posedge clk);
    #1;
    check_pin("data_term_en", 1'b1, data_term_en);
    term_req <= 1'b0;
    // self refresh with clock enable low: clock ignored
    bus_write(`SDWL_ADDR_CTRL, 16'h0001);
    cke_req <= 1'b0;
    repeat (6) @(posedge clk);
    check_reg("stat_ckign", `SDWL_ADDR_STAT, 16'h0010, 16'h0010);
    cke_req <= 1'b1;
    repeat (6) @(posedge clk);
    check_reg("stat_ckrun", `SDWL_ADDR_STAT, 16'h0000, 16'h0010);
    bus_write(`SDWL_ADDR_CTRL, 16'h0000);
    // relock: unlocked for the lock time, termination pulse flagged
    bus_write(`SDWL_ADDR_CTRL, 16'h0002);
    check_reg("ctrl_pulse", `SDWL_ADDR_CTRL, 16'h0000, 16'hFFFF);
    check_reg("stat_unlk", `SDWL_ADDR_STAT, 16'h0000, 16'h0020);
    term_req <= 1'b1;
    repeat (4) @(posedge clk);
    term_req <= 1'b0;
    repeat (4) @(posedge clk);
    check_reg("stat_viol", `SDWL_ADDR_STAT, 16'h0040, 16'h0040);
    repeat (480) @(posedge clk);
    check_reg("stat_unlk2", `SDWL_ADDR_STAT, 16'h0000, 16'h0020);
    repeat (20) @(posedge clk);
    check_reg("stat_lock", `SDWL_ADDR_STAT, 16'h0020, 16'h0020);
    bus_write(`SDWL_ADDR_STAT, 16'h0040);
    check_reg("stat_vclr", `SDWL_ADDR_STAT, 16'h0000, 16'h0040);
    give_verdict();
  end
endmodule : testbench
`default_nettype wire
